/* File: hw/pcf_alu.sv */
`timescale 1ns/10ps
`include "pcf_consts.svh"

module pcf_alu
    import pcf_pkg::*;
(
    // Operands and result
    pcf_alu_if.alu bus
);
    localparam int W = `PCF_DATA_W;
    logic [W:0] wide;

    always_comb begin
        wide = '0;
        unique case (bus.op)
            ALU_PASS: wide = {1'b0, bus.b};
            ALU_ADD: wide = {1'b0, bus.a} + {1'b0, bus.b} + (W+1)'(bus.cin);
            ALU_SUB: wide = {1'b0, bus.a} - {1'b0, bus.b};
            ALU_AND: wide = {1'b0, bus.a & bus.b};
            ALU_OR: wide = {1'b0, bus.a | bus.b};
            ALU_XOR: wide = {1'b0, bus.a ^ bus.b};
            ALU_RR: wide = {bus.a[0], bus.a[0], bus.a[W-1:1]};
            ALU_RL: wide = {bus.a[W-1], bus.a[W-2:0], bus.a[W-1]};
        endcase
        bus.y = wide[W-1:0];
        // Carry means no borrow on subtraction
        bus.cout = (bus.op == ALU_SUB) ? ~wide[W] : wide[W];
        bus.zero = (wide[W-1:0] == '0);
    end

endmodule : pcf_alu

/* File: hw/pcf_alu_if.sv */
`timescale 1ns/10ps
`include "pcf_consts.svh"

interface pcf_alu_if;
    import pcf_pkg::*;
    pcf_alu_op_t op;
    logic [`PCF_DATA_W-1:0] a;
    logic [`PCF_DATA_W-1:0] b;
    logic cin;
    logic [`PCF_DATA_W-1:0] y;
    logic cout;
    logic zero;
    modport core (output op, a, b, cin, input y, cout, zero);
    modport alu (input op, a, b, cin, output y, cout, zero);
endinterface : pcf_alu_if

/* File: hw/pcf_consts.svh */
`ifndef PCF_CONSTS_SVH
`define PCF_CONSTS_SVH

// Reset vector and instruction field layout
`define PCF_RESET_VECTOR 12'h000
`define PCF_OPC_MSB 13
`define PCF_OPC_LSB 10
`define PCF_IMM_MSB 7
`define PCF_IMM_LSB 0
`define PCF_PAGE_LSB 8
`define PCF_DATA_W 8

// Phase ring
`define PCF_PHASES 4
`define PCF_PH_FIRST 4'h1
`define PCF_PH_LAST 3

// Wake-up start-up wait, in system clock periods; one period per clk cycle
`define PCF_WAKE_TSYS 1024
`define PCF_TSYS_PER_CLK 1
`define PCF_WAKE_CYC (`PCF_WAKE_TSYS / `PCF_TSYS_PER_CLK)

`endif

/* File: hw/pcf_core.sv */
`timescale 1ns/10ps
`include "pcf_consts.svh"

// Behaviour
// RL1 - Four one-hot phases, one clock each
// RL2 - PC steps entering first phase, fetch there
// RL3 - Decode and execute in phases two to four
// RL4 - Four phases make one instruction cycle
// RL5 - Fetch overlaps execution, one per cycle
// RL6 - PC-changing instructions take one extra cycle
// RL7 - Branch discards the prefetched sequential instruction
// RL8 - RC mode copies first phase to pin; the pin stays low in the first cycle out of reset
// RL9 - Pin runs quarter rate, 1:3 duty
// RL10 - Wake-up waits 1024 clocks before fetching
// RL11 - Eight-bit ALU performs all operations
// RL12 - Data moves through accumulator and ALU
// RL13 - Taken skip replaces next with dummy
// RL14 - Low-byte PC write jumps within page
// RL15 - Reset restarts first phase, empty pipeline
module pcf_core
    import pcf_pkg::*;
#(
    parameter int PC_W = 12,
    parameter int IW = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Mode and power
    input wire logic rc_osc_mode,
    input wire logic wake_req,
    // Program memory
    output logic [PC_W-1:0] pmem_addr,
    input wire logic [IW-1:0] pmem_data,
    // Phase clocks
    output logic [`PCF_PHASES-1:0] instr_phase_clocks,
    output logic osc_output_pin,
    // Status
    output logic [`PCF_DATA_W-1:0] acc_out,
    output logic carry_out,
    output logic halted,
    output logic wakeup_startup_wait,
    output logic retire,
    output logic flush
);
    localparam int W = `PCF_DATA_W;
    localparam int WAKE_CYC = `PCF_WAKE_CYC;
    localparam int CW = $clog2(WAKE_CYC + 1);

    // Phase ring
    logic [`PCF_PHASES-1:0] phase;
    logic enter_t1;
    logic run;

    // Run state
    pcf_run_t run_st_ff, nxt_run_st;
    logic [CW-1:0] wake_cnt_ff, nxt_wake_cnt;

    // Fetch and pipeline
    logic [PC_W-1:0] pmem_addr_ff, nxt_pmem_addr;
    logic [PC_W-1:0] pc_ff, nxt_pc;
    logic [IW-1:0] pre_ir_ff, nxt_pre_ir;
    logic pre_vld_ff, nxt_pre_vld;
    logic [IW-1:0] ir_ff, nxt_ir;
    logic ir_vld_ff, nxt_ir_vld;
    pcf_opc_t opc_ff, nxt_opc;
    logic [W-1:0] imm_ff, nxt_imm;
    logic [PC_W-1:0] tgt_ff, nxt_tgt;
    logic [W-1:0] res_ff, nxt_res;
    logic res_c_ff, nxt_res_c;
    logic res_z_ff, nxt_res_z;
    logic [W-1:0] acc_ff, nxt_acc;
    logic carry_ff, nxt_carry;
    logic osc_ff, nxt_osc;
    logic retire_ff, nxt_retire;
    logic flush_ff, nxt_flush;

    // Commit decode
    logic commit;
    logic do_jump;
    logic do_skip;
    logic do_wpcl;
    logic do_halt;
    logic wr_acc;
    logic wr_carry;

    pcf_alu_if alu_bus ();

    pcf_phase_gen u_phase (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run),
        .phase_ff(phase),
        .enter_t1(enter_t1)
    );

    pcf_alu u_alu (
        .bus(alu_bus)
    );

    assign commit = phase[`PCF_PH_LAST] && ir_vld_ff;
    assign do_jump = commit && opc_ff == OP_JMP;
    assign do_skip = commit && opc_ff == OP_SZ && res_z_ff;
    assign do_wpcl = commit && opc_ff == OP_WPCL;
    assign do_halt = commit && opc_ff == OP_HALT;
    // Halting stops the ring at this edge so no stray first phase escapes
    assign run = (run_st_ff == RS_RUN) && !do_halt;

    // ALU operand selection, everything routes via the accumulator
    always_comb begin
        alu_bus.op = ALU_PASS;
        alu_bus.a = acc_ff; // [RL12]
        alu_bus.b = imm_ff;
        alu_bus.cin = 1'b0;
        unique case (opc_ff)
            OP_ADDI: alu_bus.op = ALU_ADD;
            OP_SUBI: alu_bus.op = ALU_SUB;
            OP_ANDI: alu_bus.op = ALU_AND;
            OP_ORI: alu_bus.op = ALU_OR;
            OP_XORI: alu_bus.op = ALU_XOR;
            OP_RR: alu_bus.op = ALU_RR;
            OP_RL: alu_bus.op = ALU_RL;
            OP_INC: begin
                alu_bus.op = ALU_ADD;
                alu_bus.b = W'(1);
            end
            OP_DEC: begin
                alu_bus.op = ALU_SUB;
                alu_bus.b = W'(1);
            end
            OP_CPL: begin
                alu_bus.op = ALU_XOR;
                alu_bus.b = '1;
            end
            OP_SZ, OP_WPCL: alu_bus.b = acc_ff; // [RL11]
            default: alu_bus.op = ALU_PASS;
        endcase
    end

    always_comb begin
        wr_acc = 1'b0;
        wr_carry = 1'b0;
        unique case (opc_ff)
            OP_MOVI, OP_ANDI, OP_ORI, OP_XORI, OP_CPL: wr_acc = 1'b1;
            OP_ADDI, OP_SUBI, OP_RR, OP_RL, OP_INC, OP_DEC: begin
                wr_acc = 1'b1;
                wr_carry = 1'b1;
            end
            default: wr_acc = 1'b0;
        endcase
    end

    // Run state and wake-up wait
    always_comb begin
        nxt_run_st = run_st_ff;
        nxt_wake_cnt = wake_cnt_ff;
        unique case (run_st_ff)
            RS_RUN: begin
                if (do_halt) begin
                    nxt_run_st = RS_HALT;
                end
            end
            RS_HALT: begin
                if (wake_req) begin
                    nxt_run_st = RS_WAKE;
                    nxt_wake_cnt = CW'(WAKE_CYC - 1); // [RL10]
                end
            end
            RS_WAKE: begin
                if (wake_cnt_ff == '0) begin
                    nxt_run_st = RS_RUN; // [RL10]
                end else begin
                    nxt_wake_cnt = wake_cnt_ff - CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_st_ff <= RS_RUN;
            wake_cnt_ff <= '0;
        end else begin
            run_st_ff <= nxt_run_st;
            wake_cnt_ff <= nxt_wake_cnt;
        end
    end

    // Fetch, decode, execute and commit
    always_comb begin
        nxt_pmem_addr = pmem_addr_ff;
        nxt_pc = pc_ff;
        nxt_pre_ir = pre_ir_ff;
        nxt_pre_vld = pre_vld_ff;
        nxt_ir = ir_ff;
        nxt_ir_vld = ir_vld_ff;
        nxt_opc = opc_ff;
        nxt_imm = imm_ff;
        nxt_tgt = tgt_ff;
        nxt_res = res_ff;
        nxt_res_c = res_c_ff;
        nxt_res_z = res_z_ff;
        nxt_acc = acc_ff;
        nxt_carry = carry_ff;
        nxt_retire = 1'b0;
        nxt_flush = 1'b0;
        nxt_osc = rc_osc_mode && enter_t1; // [RL8] [RL9]
        if (enter_t1) begin
            nxt_pmem_addr = pc_ff; // [RL2]
            nxt_pc = pc_ff + PC_W'(1); // [RL2]
        end
        if (phase[0]) begin
            // Fetch the next word while the previous one enters execution
            nxt_pre_ir = pmem_data; // [RL2] [RL5]
            nxt_pre_vld = 1'b1;
            nxt_ir = pre_ir_ff; // [RL5]
            nxt_ir_vld = pre_vld_ff;
        end
        if (phase[1]) begin
            nxt_opc = pcf_opc_t'(ir_ff[`PCF_OPC_MSB:`PCF_OPC_LSB]); // [RL3]
            nxt_imm = ir_ff[`PCF_IMM_MSB:`PCF_IMM_LSB];
            nxt_tgt = ir_ff[PC_W-1:0];
        end
        if (phase[2]) begin
            nxt_res = alu_bus.y; // [RL3] [RL11]
            nxt_res_c = alu_bus.cout;
            nxt_res_z = alu_bus.zero;
        end
        if (commit) begin
            nxt_retire = 1'b1;
            if (wr_acc) begin
                nxt_acc = res_ff; // [RL12]
            end
            if (wr_carry) begin
                nxt_carry = res_c_ff;
            end
        end
        if (do_jump) begin
            nxt_pmem_addr = tgt_ff; // [RL6] [RL7]
            nxt_pc = tgt_ff + PC_W'(1);
        end
        if (do_wpcl) begin
            nxt_pmem_addr = {pmem_addr_ff[PC_W-1:`PCF_PAGE_LSB], res_ff};
            nxt_pc = {pmem_addr_ff[PC_W-1:`PCF_PAGE_LSB], res_ff}
                     + PC_W'(1); // [RL14]
        end
        if (do_jump || do_wpcl || do_skip) begin
            // Sequential word fetched this cycle becomes a dummy cycle
            nxt_pre_vld = 1'b0; // [RL7] [RL13] [RL14]
            nxt_flush = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pmem_addr_ff <= `PCF_RESET_VECTOR; // [RL15]
            pc_ff <= `PCF_RESET_VECTOR + PC_W'(1);
            pre_ir_ff <= '0;
            pre_vld_ff <= 1'b0; // [RL15]
            ir_ff <= '0;
            ir_vld_ff <= 1'b0;
            opc_ff <= OP_NOP;
            imm_ff <= '0;
            tgt_ff <= '0;
            res_ff <= '0;
            res_c_ff <= 1'b0;
            res_z_ff <= 1'b0;
            acc_ff <= '0;
            carry_ff <= 1'b0;
            osc_ff <= 1'b0;
            retire_ff <= 1'b0;
            flush_ff <= 1'b0;
        end else begin
            pmem_addr_ff <= nxt_pmem_addr;
            pc_ff <= nxt_pc;
            pre_ir_ff <= nxt_pre_ir;
            pre_vld_ff <= nxt_pre_vld;
            ir_ff <= nxt_ir;
            ir_vld_ff <= nxt_ir_vld;
            opc_ff <= nxt_opc;
            imm_ff <= nxt_imm;
            tgt_ff <= nxt_tgt;
            res_ff <= nxt_res;
            res_c_ff <= nxt_res_c;
            res_z_ff <= nxt_res_z;
            acc_ff <= nxt_acc;
            carry_ff <= nxt_carry;
            osc_ff <= nxt_osc;
            retire_ff <= nxt_retire;
            flush_ff <= nxt_flush;
        end
    end

    assign pmem_addr = pmem_addr_ff;
    assign instr_phase_clocks = phase;
    assign osc_output_pin = osc_ff;
    assign acc_out = acc_ff;
    assign carry_out = carry_ff;
    assign halted = (run_st_ff == RS_HALT);
    assign wakeup_startup_wait = (run_st_ff == RS_WAKE);
    assign retire = retire_ff;
    assign flush = flush_ff;

    property p_pc_step;
        @(posedge clk) disable iff (sys_rst)
        (phase[`PCF_PH_LAST] && run && !do_jump && !do_wpcl)
        |=> pmem_addr_ff == $past(pc_ff) && pc_ff == $past(pc_ff) + 1'b1;
    endproperty
    a_pc_step: assert property (p_pc_step) // [RL2]
        else $error("Program counter did not step into first phase");

    property p_decode_t2;
        @(posedge clk) disable iff (sys_rst)
        phase[1] |=> opc_ff == $past(ir_ff[`PCF_OPC_MSB:`PCF_OPC_LSB]);
    endproperty
    a_decode_t2: assert property (p_decode_t2) // [RL3]
        else $error("Decode not taken in second phase");

    property p_branch_extra;
        @(posedge clk) disable iff (sys_rst)
        (do_jump && run) |=> (flush_ff && retire_ff) ##4 !retire_ff;
    endproperty
    a_branch_extra: assert property (p_branch_extra) // [RL6]
        else $error("Branch did not cost one dummy cycle");

    property p_jump_target;
        @(posedge clk) disable iff (sys_rst)
        do_jump |=> pmem_addr_ff == $past(tgt_ff) && !pre_vld_ff;
    endproperty
    a_jump_target: assert property (p_jump_target) // [RL7]
        else $error("Jump target not fetched or prefetch kept");

    property p_osc_duty;
        @(posedge clk) disable iff (sys_rst)
        $rose(osc_ff) |-> phase[0] ##1 !osc_ff[*3];
    endproperty
    a_osc_duty: assert property (p_osc_duty) // [RL9]
        else $error("Phase pin duty is not 1:3");

    property p_osc_mode;
        @(posedge clk) disable iff (sys_rst)
        osc_ff |-> $past(rc_osc_mode);
    endproperty
    a_osc_mode: assert property (p_osc_mode) // [RL8]
        else $error("Phase pin driven outside RC mode");

    property p_wake_wait;
        @(posedge clk) disable iff (sys_rst)
        (run_st_ff == RS_HALT && wake_req)
        |=> wake_cnt_ff == CW'(WAKE_CYC - 1) && phase == '0;
    endproperty
    a_wake_wait: assert property (p_wake_wait) // [RL10]
        else $error("Start-up wait not loaded on wake");

    property p_wake_end;
        @(posedge clk) disable iff (sys_rst)
        (run_st_ff == RS_WAKE && wake_cnt_ff == '0) |=> ##1 phase[0];
    endproperty
    a_wake_end: assert property (p_wake_end) // [RL10]
        else $error("Fetch did not resume after start-up wait");

    property p_alu_add;
        @(posedge clk) disable iff (sys_rst)
        (phase[2] && alu_bus.op == ALU_ADD)
        |=> res_ff == W'($past(alu_bus.a) + $past(alu_bus.b));
    endproperty
    a_alu_add: assert property (p_alu_add) // [RL11]
        else $error("Eight-bit add result wrong");

    property p_skip_dummy;
        @(posedge clk) disable iff (sys_rst)
        (do_skip && run) |=> flush_ff ##4 !retire_ff;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) // [RL13]
        else $error("Taken skip did not insert a dummy cycle");

    property p_wpcl_page;
        @(posedge clk) disable iff (sys_rst)
        do_wpcl |=> pmem_addr_ff[W-1:0] == $past(acc_ff)
            && pmem_addr_ff[PC_W-1:W] == $past(pmem_addr_ff[PC_W-1:W]);
    endproperty
    a_wpcl_page: assert property (p_wpcl_page) // [RL14]
        else $error("Low-byte write left the page");

    property p_reset_start;
        @(posedge clk) $past(sys_rst) && !sys_rst
        |-> phase == `PCF_PH_FIRST && pmem_addr_ff == `PCF_RESET_VECTOR
            && !pre_vld_ff && !ir_vld_ff;
    endproperty
    a_reset_start: assert property (p_reset_start) // [RL15]
        else $error("Reset did not restart the pipeline");

endmodule : pcf_core

/* File: hw/pcf_phase_gen.sv */
`timescale 1ns/10ps
`include "pcf_consts.svh"

module pcf_phase_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    // Phases
    output logic [`PCF_PHASES-1:0] phase_ff,
    output logic enter_t1
);
    logic [`PCF_PHASES-1:0] nxt_phase;

    // A stopped ring shows no phase and restarts at the first one
    assign enter_t1 = run && (phase_ff[`PCF_PH_LAST] || phase_ff == '0);

    always_comb begin
        nxt_phase = '0;
        if (enter_t1) begin
            nxt_phase = `PCF_PH_FIRST; // [RL1]
        end else if (run) begin
            nxt_phase = phase_ff << 1; // [RL1]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_ff <= `PCF_PH_FIRST; // [RL15]
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // A ring restarting from idle shows no phase for that one clock
    property p_phase_onehot;
        @(posedge clk) disable iff (sys_rst)
        (run && phase_ff != '0) |-> $onehot(phase_ff);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) // [RL1]
        else $error("Phase ring not one-hot while running");

    property p_phase_idle;
        @(posedge clk) disable iff (sys_rst) !run |=> phase_ff == '0;
    endproperty
    a_phase_idle: assert property (p_phase_idle) // [RL1]
        else $error("Phase ring kept running while stopped");

    property p_cycle_four;
        @(posedge clk) disable iff (sys_rst)
        (phase_ff[0] && run) ##1 run[*3] |=> phase_ff[0];
    endproperty
    a_cycle_four: assert property (p_cycle_four) // [RL4]
        else $error("Instruction cycle is not four clocks");

endmodule : pcf_phase_gen

/* File: hw/pcf_pkg.sv */
package pcf_pkg;

    typedef enum logic [3:0] {
        OP_NOP, OP_MOVI, OP_ADDI, OP_SUBI, OP_ANDI, OP_ORI, OP_XORI, OP_RR,
        OP_RL, OP_INC, OP_DEC, OP_CPL, OP_JMP, OP_SZ, OP_WPCL, OP_HALT
    } pcf_opc_t;

    typedef enum logic [2:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RR, ALU_RL
    } pcf_alu_op_t;

    typedef enum logic [1:0] {RS_RUN, RS_HALT, RS_WAKE} pcf_run_t;

endpackage : pcf_pkg

/* File: sim/pcf_pmem_model.sv */
`timescale 1ns/10ps
`include "pcf_consts.svh"

module pcf_pmem_model #(
    parameter int PC_W = 12,
    parameter int IW = 14
) (
    // Fetch side
    input wire logic [PC_W-1:0] addr,
    input wire logic [`PCF_PHASES-1:0] phase,
    output logic [IW-1:0] data
);
    logic [IW-1:0] mem [0:(1<<PC_W)-1];

    // Only valid in the first phase; scrambled elsewhere so a late sample
    // cannot pass by luck
    always_comb begin
        data = phase[0] ? mem[addr] : ~mem[addr];
    end
endmodule : pcf_pmem_model

/* File: sim/test_phase_clock_fetch_pipeline.sv */
`timescale 1ns/10ps
`include "pcf_consts.svh"

module test_phase_clock_fetch_pipeline;
    import pcf_pkg::*;
    logic clk;
    logic sys_rst;
    logic rc_osc_mode;
    logic wake_req;
    logic [11:0] pmem_addr;
    logic [13:0] pmem_data;
    logic [3:0] ph;
    logic osc;
    logic [7:0] acc;
    logic carry;
    logic halted;
    logic waiting;
    logic retire;
    logic flush;
    int bad_count;
    int num_checks;
    int seed;
    int cyc;
    int tot;
    int exp_t;
    int n;
    bit run1;
    int q_acc[$];
    int q_car[$];
    int q_gap[$];
    int q_chg[$];

    pcf_core u_pcf_core (.clk(clk), .sys_rst(sys_rst),
        .rc_osc_mode(rc_osc_mode), .wake_req(wake_req),
        .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .instr_phase_clocks(ph), .osc_output_pin(osc), .acc_out(acc),
        .carry_out(carry), .halted(halted), .wakeup_startup_wait(waiting),
        .retire(retire), .flush(flush));

    pcf_pmem_model u_pcf_pmem_model (.addr(pmem_addr), .phase(ph),
        .data(pmem_data));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            $display("ERROR %0t %s", $time, msg);
            bad_count++;
        end
    endtask : check

    task conclude;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task limit(input int cnt, input int lim);
        if (cnt >= lim) begin
            check(1'b0, "wait ran out");
            conclude();
        end
    endtask : limit

    task put(input int a, input pcf_opc_t op, input int imm);
        u_pcf_pmem_model.mem[a] = 14'((int'(op) << 10) | imm);
    endtask : put

    // Instruction-level model; carry of -1 means not compared
    task build_model;
        int pc;
        int a;
        int c;
        int w;
        int imm;
        int npc;
        int chg;
        pc = 0;
        a = 0;
        c = 0;
        repeat (24) begin
            w = int'(u_pcf_pmem_model.mem[pc]);
            imm = w & 255;
            npc = (pc + 1) & 4095;
            chg = 0;
            case (w >> 10)
                OP_MOVI: a = imm;
                OP_ADDI: begin
                    c = (a + imm) >> 8;
                    a = (a + imm) & 255;
                end
                OP_SUBI: begin
                    a = (a - imm) & 255;
                    c = -1;
                end
                OP_ANDI: a = a & imm;
                OP_ORI: a = a | imm;
                OP_XORI: a = a ^ imm;
                OP_RR: begin
                    a = (a >> 1) | ((a & 1) << 7);
                    c = -1;
                end
                OP_RL: begin
                    a = ((a << 1) & 255) | (a >> 7);
                    c = -1;
                end
                OP_INC: begin
                    a = (a + 1) & 255;
                    c = -1;
                end
                OP_DEC: begin
                    a = (a - 1) & 255;
                    c = -1;
                end
                OP_CPL: begin
                    a = 255 - a;
                    c = -1;
                end
                OP_JMP: begin
                    npc = w & 4095;
                    chg = 1;
                end
                OP_SZ: begin
                    if (a == 0) begin
                        npc = (pc + 2) & 4095;
                        chg = 1;
                    end
                end
                OP_WPCL: begin
                    npc = ((pc + 1) & 3840) | a;
                    chg = 1;
                end
                default: ;
            endcase
            q_acc.push_back(a);
            q_car.push_back(c);
            q_gap.push_back(chg ? 8 : 4);
            q_chg.push_back(chg);
            pc = npc;
        end
    endtask : build_model

    // Wake requests while running must be ignored
    always @(posedge clk) begin
        if (run1) begin
            wake_req <= 1'($random(seed));
        end
    end

    always @(negedge clk) begin
        tot++;
        if (tot > 20000) begin
            check(1'b0, "run too long");
            conclude();
        end
        if (sys_rst) begin
            cyc = 0;
        end else if (run1) begin
            check(ph === 4'(1 << (cyc % 4)), "phase ring");
            // Pin is low in the very first cycle out of reset
            check(osc === 1'(cyc % 4 == 0 && cyc > 0), "osc pin");
            check(halted === 1'b0, "halted by stray wake");
            if (flush === 1'b1) begin
                check(retire === 1'b1, "stray flush");
            end
            if (q_acc.size() > 0 && (retire === 1'b1 || cyc == exp_t)) begin
                check(retire === 1'b1 && cyc == exp_t, "retire time");
                check(acc === 8'(q_acc[0]), "acc value");
                if (q_car[0] >= 0) begin
                    check(carry === 1'(q_car[0]), "carry value");
                end
                check(flush === 1'(q_chg[0]), "flush");
                exp_t += q_gap[0];
                void'(q_acc.pop_front());
                void'(q_car.pop_front());
                void'(q_gap.pop_front());
                void'(q_chg.pop_front());
            end
            cyc++;
        end
    end

    initial begin
        sys_rst = 1'b1;
        rc_osc_mode = 1'b1;
        wake_req = 1'b0;
        bad_count = 0;
        num_checks = 0;
        seed = 82;
        tot = 0;
        cyc = 0;
        exp_t = 8;
        run1 = 1'b0;
        for (int i = 0; i < 4096; i++) begin
            u_pcf_pmem_model.mem[i] = '0;
        end
        // Every ALU operation once, then skips, jump and page-kept PC write
        for (int i = 0; i < 11; i++) begin
            put(i, pcf_opc_t'(i + 1), $random(seed) & 255);
        end
        put(11, OP_SZ, 0);
        put(12, OP_JMP, 'h120);
        put(13, OP_MOVI, 'hFF);
        put('h120, OP_MOVI, 0);
        put('h121, OP_SZ, 0);
        put('h122, OP_MOVI, 'h11);
        put('h123, OP_MOVI, 'h40);
        put('h124, OP_WPCL, 0);
        put('h125, OP_MOVI, 'hEE);
        put('h140, OP_NOP, 0);
        put('h141, OP_JMP, 'h141);
        build_model();
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        run1 = 1'b1;
        @(negedge clk);
        check(pmem_addr === 12'h000 && acc === 8'h00 && halted === 1'b0, "reset");
        for (n = 0; n < 400 && q_acc.size() > 0; n++) @(negedge clk);
        limit(n, 400);
        // Second reset in mid-run, then halt and wake
        @(posedge clk);
        run1 = 1'b0;
        sys_rst <= 1'b1;
        wake_req <= 1'b0;
        rc_osc_mode <= 1'b0;
        put(0, OP_MOVI, 'h5A);
        put(1, OP_HALT, 0);
        put(2, OP_MOVI, 'h33);
        put(3, OP_JMP, 3);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (n = 0; n < 40 && halted !== 1'b1; n++) @(negedge clk);
        limit(n, 40);
        check(ph === 4'h0 && acc === 8'h5A && osc === 1'b0, "halt state");
        repeat (20) @(negedge clk);
        check(halted === 1'b1 && waiting === 1'b0 && ph === 4'h0, "halt hold");
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        for (n = 0; n < 4 && waiting !== 1'b1; n++) @(negedge clk);
        limit(n, 4);
        for (n = 0; n < 2000 && waiting === 1'b1; n++) begin
            check(ph === 4'h0, "phase during wait");
            @(negedge clk);
        end
        check(n == `PCF_WAKE_CYC, "start-up wait length");
        check(ph === 4'h0, "phase at wait end");
        @(negedge clk);
        check(ph === 4'h1, "fetch resumes");
        for (n = 0; n < 40 && acc !== 8'h33; n++) @(negedge clk);
        limit(n, 40);
        check(halted === 1'b0 && osc === 1'b0, "after wake");
        conclude();
    end
endmodule : test_phase_clock_fetch_pipeline
